// File: shared/adcsc_map.vh
// Register map, field positions and timing constants of the converter sequencing control
`ifndef ADCSC_MAP_VH
`define ADCSC_MAP_VH

// ******************************************************************
// Register offsets
// ******************************************************************
`define ADCSC_ADDR_W        8
`define ADCSC_OFF_CSR       8'h70
`define ADCSC_OFF_RES_HIGH  8'h71
`define ADCSC_OFF_RES_LOW   8'h72

// ******************************************************************
// Control/status fields
// ******************************************************************
`define ADCSC_DONE_BIT      7
`define ADCSC_SPEED_BIT     6
`define ADCSC_ON_BIT        5
`define ADCSC_RSVD_BIT      4
`define ADCSC_CH_HI         3
`define ADCSC_CH_LO         0

// ******************************************************************
// Reset values and constants
// ******************************************************************
`define ADCSC_RESET_BYTE    8'h00
`define ADCSC_RESET_RES     10'h000
`define ADCSC_FULL_SCALE    10'h3FF
`define ADCSC_ZERO_SCALE    10'h000
`define ADCSC_LOW_PAD       6'h00
`define ADCSC_RES_W         10
`define ADCSC_SAMPLE_CYC    4'h3
`define ADCSC_LAST_BIT      4'h9
`define ADCSC_DIV4_LAST     2'h3
`define ADCSC_DIV2_LAST     2'h1
`define ADCSC_DIV_ZERO      2'h0

`endif

// File: design/adcsc_sar_step.v
// One successive-approximation step engine for a 10-bit result
`timescale 1ns/1ps
`include "adcsc_map.vh"

module adcsc_sar_step (
   input  wire       clk_i,
   input  wire       reset_n_i,
   input  wire       start_i,
   input  wire       abort_i,
   input  wire       step_en_i,
   input  wire       cmp_above_i,
   output reg  [9:0] trial_o,
   output reg        busy_o,
   output reg        done_o
);

   reg [3:0] bit_idx;
   reg [3:0] samp_cnt;
   reg       sampling;
   reg [9:0] mask;
   reg       settle;

   // ******************************************************************
   // Sampling then one bit decided per two conversion-clock enables
   // ******************************************************************
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         trial_o  <= `ADCSC_RESET_RES;
         busy_o   <= 1'b0;
         done_o   <= 1'b0;
         bit_idx  <= 4'h0;
         samp_cnt <= 4'h0;
         sampling <= 1'b0;
         mask     <= 10'h000;
         settle   <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (abort_i) begin
            busy_o   <= 1'b0;
            sampling <= 1'b0;
         end else if (start_i) begin
            busy_o   <= 1'b1;
            sampling <= 1'b1;
            samp_cnt <= 4'h0;
            bit_idx  <= 4'h0;
            mask     <= 10'h200;
            trial_o  <= 10'h200;
            settle   <= 1'b0;
         end else if (busy_o && step_en_i) begin
            if (sampling) begin
               samp_cnt <= samp_cnt + 4'h1;
               if (samp_cnt == `ADCSC_SAMPLE_CYC)
                  sampling <= 1'b0;
            end else begin
               // Comparator path lags the trial by three clocks, so each bit gets two enables
               settle <= !settle;
               if (settle) begin
                  // Keep or drop the trial bit, then try the next lower one
                  if (!cmp_above_i)
                     trial_o <= (trial_o & ~mask) | (mask >> 1);
                  else
                     trial_o <= trial_o | (mask >> 1);
                  mask    <= mask >> 1;
                  bit_idx <= bit_idx + 4'h1;
                  if (bit_idx == `ADCSC_LAST_BIT) begin
                     busy_o <= 1'b0;
                     done_o <= 1'b1;
                     if (!cmp_above_i)
                        trial_o <= trial_o & ~mask;
                     else
                        trial_o <= trial_o;
                  end
               end
            end
         end
      end
   end

endmodule

// File: design/adcsc_top.v
// Control, register file and sequencing of the 10-bit converter
`timescale 1ns/1ps
`include "adcsc_map.vh"
// What this block does
// - Input above upper reference reports all ones, no overflow flag.
// - Input below lower reference reports zero in both result registers.
// - Setting converter_on powers up and converts continuously until cleared.
// - Each completion while active and without a same-cycle channel change sets the done flag and loads the new result.
// - Reading the high result register clears the done flag.
// - A control_status write clears the done flag unless a completion without channel change lands in the same cycle.
// - Results are not latched; next completion overwrites both registers.
// - Channel change aborts, clears done, restarts on the new channel.
// - Clock select bit: zero divides by four, one divides by two.
// - Clearing converter_on stops conversion and disables the converter.
// - Four-bit channel_select picks analog input zero to fifteen in binary.
// - High result register holds result bits nine down to two.
// - Low result register reads zeros above result bits one and zero.
// - Control_status read/write except done flag, set only by hardware, and reserved bit four, never stored and read as zero.
// - Wait mode leaves converter running; halt mode disables it.
// - Reset clears all registers: converter off, channel zero.

module adcsc_top (
   input  wire       clk_i,
   input  wire       reset_n_i,
   input  wire [7:0] addr_i,
   input  wire [7:0] wdata_i,
   input  wire       wr_i,
   input  wire       rd_i,
   output reg  [7:0] rdata_o,
   input  wire       halt_i,
   input  wire       cmp_above_i,
   input  wire       over_range_i,
   input  wire       under_range_i,
   output reg  [3:0] analog_input_n_o,
   output reg  [9:0] dac_trial_o,
   output reg        converter_power_o,
   output reg        sample_o
);

   // ******************************************************************
   // Synchronisers for the analog-side levels and halt
   // ******************************************************************
   reg [1:0] cmp_sync;
   reg [1:0] over_sync;
   reg [1:0] under_sync;
   reg [1:0] halt_sync;

   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cmp_sync   <= 2'h0;
         over_sync  <= 2'h0;
         under_sync <= 2'h0;
         halt_sync  <= 2'h0;
      end else begin
         cmp_sync   <= {cmp_sync[0], cmp_above_i};
         over_sync  <= {over_sync[0], over_range_i};
         under_sync <= {under_sync[0], under_range_i};
         halt_sync  <= {halt_sync[0], halt_i};
      end
   end

   wire cmp_s   = cmp_sync[1];
   wire over_s  = over_sync[1];
   wire under_s = under_sync[1];
   wire halt_s  = halt_sync[1];

   // ******************************************************************
   // Control/status register
   // ******************************************************************
   reg       done_flag;
   reg       clock_select;
   reg       converter_on;
   reg [3:0] channel_select;
   reg [9:0] result;

   wire wr_csr   = wr_i && (addr_i == `ADCSC_OFF_CSR);
   wire rd_high  = rd_i && (addr_i == `ADCSC_OFF_RES_HIGH);
   wire ch_change = wr_csr && (wdata_i[`ADCSC_CH_HI:`ADCSC_CH_LO] != channel_select);
   // Wait mode needs no input: only halt gates the converter
   wire active   = converter_on && !halt_s;

   wire       conv_done;
   wire       conv_busy;
   wire [9:0] trial;

   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         clock_select   <= 1'b0;
         converter_on   <= 1'b0;
         channel_select <= 4'h0;
      end else if (wr_csr) begin
         // Reserved bit and done flag are never stored
         clock_select   <= wdata_i[`ADCSC_SPEED_BIT];
         converter_on   <= wdata_i[`ADCSC_ON_BIT];
         channel_select <= wdata_i[`ADCSC_CH_HI:`ADCSC_CH_LO];
      end
   end

   // ******************************************************************
   // Done flag and result
   // ******************************************************************
   // Completion wins over a clear in the same cycle so no result is missed,
   // except when the write also changes channel, which aborts it anyway
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         done_flag <= 1'b0;
         result    <= `ADCSC_RESET_RES;
      end else begin
         if (conv_done && active && !ch_change) begin
            done_flag <= 1'b1;
            // Saturation uses the range comparators, no overflow flag
            if (over_s)
               result <= `ADCSC_FULL_SCALE;
            else if (under_s)
               result <= `ADCSC_ZERO_SCALE;
            else
               result <= trial;
         end else if (rd_high || wr_csr) begin
            done_flag <= 1'b0;
         end
      end
   end

   // ******************************************************************
   // Conversion clock divider
   // ******************************************************************
   reg [1:0] div_cnt;
   reg       step_en;
   wire [1:0] div_last = clock_select ? `ADCSC_DIV2_LAST : `ADCSC_DIV4_LAST;

   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         div_cnt <= `ADCSC_DIV_ZERO;
         step_en <= 1'b0;
      end else if (!active) begin
         div_cnt <= `ADCSC_DIV_ZERO;
         step_en <= 1'b0;
      end else if (div_cnt >= div_last) begin
         div_cnt <= `ADCSC_DIV_ZERO;
         step_en <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 2'h1;
         step_en <= 1'b0;
      end
   end

   // ******************************************************************
   // Sequencer
   // ******************************************************************
   localparam ST_OFF   = 3'b001;
   localparam ST_START = 3'b010;
   localparam ST_CONV  = 3'b100;

   reg [2:0] state;
   reg [2:0] next_state;
   wire      abort = !active || ch_change;

   always @* begin
      next_state = state;
      case (state)
         ST_OFF:   if (active) next_state = ST_START;
         ST_START: next_state = abort ? ST_OFF : ST_CONV;
         ST_CONV: begin
            if (!active)
               next_state = ST_OFF;
            else if (ch_change || conv_done)
               next_state = ST_START;
         end
         default:  next_state = ST_OFF;
      endcase
   end

   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         state <= ST_OFF;
      else
         state <= next_state;
   end

   wire start_conv = (state == ST_START) && !abort;

   adcsc_sar_step u_sar (
      .clk_i       (clk_i),
      .reset_n_i   (reset_n_i),
      .start_i     (start_conv),
      .abort_i     (abort),
      .step_en_i   (step_en),
      .cmp_above_i (cmp_s),
      .trial_o     (trial),
      .busy_o      (conv_busy),
      .done_o      (conv_done)
   );

   // ******************************************************************
   // Outputs to the analog side and read data
   // ******************************************************************
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         analog_input_n_o  <= 4'h0;
         dac_trial_o       <= `ADCSC_RESET_RES;
         converter_power_o <= 1'b0;
         sample_o          <= 1'b0;
         rdata_o           <= `ADCSC_RESET_BYTE;
      end else begin
         analog_input_n_o  <= channel_select;
         dac_trial_o       <= trial;
         converter_power_o <= active;
         sample_o          <= start_conv;
         if (rd_i) begin
            case (addr_i)
               `ADCSC_OFF_CSR:
                  rdata_o <= {done_flag, clock_select, converter_on, 1'b0, channel_select};
               `ADCSC_OFF_RES_HIGH:
                  rdata_o <= result[9:2];
               `ADCSC_OFF_RES_LOW:
                  rdata_o <= {`ADCSC_LOW_PAD, result[1:0]};
               default:
                  rdata_o <= `ADCSC_RESET_BYTE;
            endcase
         end else begin
            rdata_o <= `ADCSC_RESET_BYTE;
         end
      end
   end

endmodule

// File: verif/adcsc_checker.sv
// Port checker for the converter sequencing control
`timescale 1ns/1ps
module adcsc_checker (
   input wire       clk_i,
   input wire       reset_n_i,
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   input wire       wr_i,
   input wire       rd_i,
   input wire [7:0] rdata_o,
   input wire       halt_i,
   input wire [3:0] analog_input_n_o,
   input wire       converter_power_o,
   input wire       sample_o
);
   reg  [3:0] ch;
   wire       wcsr = wr_i && addr_i == 8'h70;
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         ch <= 4'h0;
      else if (wcsr)
         ch <= wdata_i[3:0];
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_chg; wcsr && wdata_i[3:0] != ch; endsequence
   sequence s_rd_csr; rd_i && addr_i == 8'h70; endsequence
   property p_idle; !rd_i |=> rdata_o == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("read data not idle");
   property p_pad; rd_i && addr_i == 8'h72 |=> rdata_o[7:2] == 6'h00; endproperty
   a_pad: assert property (p_pad) else $error("low pad not zero");
   property p_rsvd; s_rd_csr |=> !rdata_o[4]; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
   property p_unmap; rd_i && (addr_i < 8'h70 || addr_i > 8'h72) |=> rdata_o == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_chg; s_chg ##1 s_rd_csr |=> !rdata_o[7]; endproperty
   a_chg: assert property (p_chg) else $error("done kept on channel change");
   property p_mux; wcsr |-> ##2 analog_input_n_o == $past(wdata_i[3:0], 2); endproperty
   a_mux: assert property (p_mux) else $error("mux select wrong");
   property p_off; wcsr && !wdata_i[5] |-> ##2 !converter_power_o; endproperty
   a_off: assert property (p_off) else $error("power stays on");
   property p_halt; halt_i [*4] |-> !converter_power_o; endproperty
   a_halt: assert property (p_halt) else $error("power on in halt");
   property p_samp; sample_o |=> !sample_o [*8]; endproperty
   a_samp: assert property (p_samp) else $error("sample too soon");
endmodule
bind adcsc_top adcsc_checker u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .halt_i(halt_i), .analog_input_n_o(analog_input_n_o),
   .converter_power_o(converter_power_o), .sample_o(sample_o));

// File: verif/adcsc_top_tb.sv
// Self-checking bench for the converter sequencing control
`timescale 1ns/1ps
module adcsc_top_tb;
   reg         clk_i, reset_n_i, wr_i, rd_i, halt_i, over_range_i, under_range_i, pend;
   reg  [7:0]  addr_i, wdata_i, last_rd;
   reg  [9:0]  tgt;
   reg  [31:0] r;
   reg  [15:0] ent;
   wire [7:0]  rdata_o;
   wire [3:0]  analog_input_n_o;
   wire [9:0]  dac_trial_o;
   wire        converter_power_o, sample_o;
   wire        cmp_above_i = tgt >= dac_trial_o;
   integer     n_mismatch, checks, i;
   reg  [15:0] q[$];
   adcsc_top uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .halt_i(halt_i), .cmp_above_i(cmp_above_i), .over_range_i(over_range_i),
      .under_range_i(under_range_i), .analog_input_n_o(analog_input_n_o), .dac_trial_o(dac_trial_o),
      .converter_power_o(converter_power_o), .sample_o(sample_o));
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   task chk(input [7:0] seen, input [7:0] ex);
      begin
         checks++;
         if (seen !== ex) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, ex);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("mismatches %0d checks %0d", n_mismatch, checks);
         if (n_mismatch == 0 && checks > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   // ******************************************************************
   // Read monitor: oldest note against the data in the cycle after rd
   // ******************************************************************
   always @(posedge clk_i) begin
      if (pend) begin
         last_rd = rdata_o;
         ent = q.pop_front();
         if (ent[15:8] != 8'h00)
            chk(rdata_o & ent[15:8], ent[7:0]);
      end
      pend <= rd_i;
   end
   task bus(input w, input [7:0] a, input [7:0] d, input [7:0] e, input [7:0] m);
      begin
         wr_i <= w;
         rd_i <= !w;
         addr_i <= a;
         wdata_i <= d;
         if (!w)
            q.push_back({m, e});
         @(posedge clk_i);
      end
   endtask
   task idle;
      begin
         wr_i <= 1'b0;
         rd_i <= 1'b0;
         @(posedge clk_i);
      end
   endtask
   task wrx(input [7:0] a, input [7:0] d);
      begin
         bus(1'b1, a, d, 8'h00, 8'h00);
         idle;
      end
   endtask
   task rdx(input [7:0] a, input [7:0] e);
      begin
         bus(1'b0, a, 8'h00, e, 8'hFF);
         idle;
      end
   endtask
   // Bounded poll; a poll read does not clear the flag
   task wait_done;
      integer k;
      begin
         last_rd = 8'h00;
         k = 0;
         while (last_rd[7] !== 1'b1) begin
            if (k == 100) begin
               n_mismatch++;
               give_verdict;
            end
            k++;
            bus(1'b0, 8'h70, 8'h00, 8'h00, 8'h00);
            idle;
            idle;
         end
      end
   endtask
   // Restart from off; two completions show back-to-back conversion
   task conv(input [7:0] cfg, input [9:0] ex);
      begin
         wrx(8'h70, 8'h00);
         wrx(8'h70, cfg);
         repeat (2) begin
            wait_done;
            rdx(8'h72, {6'h00, ex[1:0]});
            rdx(8'h71, ex[9:2]);
            rdx(8'h70, cfg);
         end
      end
   endtask
   initial begin
      n_mismatch = 0;
      checks = 0;
      r = $urandom(32'h3115);
      {reset_n_i, wr_i, rd_i, halt_i, over_range_i, under_range_i, pend} = 7'h00;
      {addr_i, wdata_i, last_rd, tgt} = 34'h0;
      repeat (16) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      for (i = 8'h70; i < 8'h74; i++)
         rdx(i[7:0], 8'h00);
      wrx(8'h71, 8'hFF);
      rdx(8'h71, 8'h00);
      wrx(8'h70, 8'h9F);
      rdx(8'h70, 8'h0F);
      $display("test registers done");
      for (i = 0; i < 16; i++) begin
         wrx(8'h70, i[7:0]);
         @(posedge clk_i);
         chk({4'h0, analog_input_n_o}, i[7:0]);
      end
      $display("test channels done");
      over_range_i <= 1'b1;
      conv(8'h20, 10'h3FF);
      over_range_i <= 1'b0;
      under_range_i <= 1'b1;
      conv(8'h27, 10'h000);
      under_range_i <= 1'b0;
      $display("test saturation done");
      for (i = 0; i < 2; i++) begin
         r = $urandom;
         tgt = r[9:0];
         conv({1'b0, i[0], 6'h23}, tgt);
      end
      $display("test conversion done");
      repeat (8) @(posedge clk_i);
      bus(1'b1, 8'h70, 8'h65, 8'h00, 8'h00);
      bus(1'b0, 8'h70, 8'h00, 8'h65, 8'hFF);
      idle;
      wait_done;
      rdx(8'h71, tgt[9:2]);
      rdx(8'h70, 8'h65);
      halt_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk({7'h0, converter_power_o}, 8'h00);
      halt_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk({7'h0, converter_power_o}, 8'h01);
      wrx(8'h70, 8'h45);
      repeat (2) @(posedge clk_i);
      chk({7'h0, converter_power_o}, 8'h00);
      $display("test power done");
      give_verdict;
   end
endmodule
